// ==== ctpwm_top.sv ====
// Purpose: compact timer with compare-match, timer/counter and pwm output
// Assumes: classic wishbone slave, byte registers in lane 0
// Notes:   answer comes one cycle after the request; writes land on the ack edge
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
module ctpwm_top #(
  parameter int CNT_W = ctpwm_pkg::CNT_W,
  parameter int P_W   = ctpwm_pkg::P_W
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             match_a_flag,
  output logic             match_p_flag
);
  import ctpwm_pkg::*;

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (CNT_W <= 8 || CNT_W > 16 || P_W > 8) begin : g_bad
    $error("ctpwm_top: CNT_W must be 9..16 and P_W at most 8");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]       ctrl1_r;
  logic             on_r;
  logic             on_prev_r;
  logic [CNT_W-1:0] cmpa_r;
  logic [P_W-1:0]   cmpp_r;
  logic             fa_r;
  logic             fp_r;
  logic             cmo_st_r;
  logic             pin_r;
  logic             oe_r;
  logic             ack_r;
  logic [31:0]      rdat_r;

  // ****************************************************************
  // decode
  // ****************************************************************
  ctpwm_mode_e      mode;
  ctpwm_ofn_e       ofn;
  logic             oc;
  logic             pol;
  logic             dpx;
  logic             ccl;
  logic             is_pwm;
  logic             is_cmo;
  logic             restart;
  logic [CNT_W-1:0] count;
  logic             hit_a;
  logic             hit_p;
  logic             wave_act;

  assign mode    = ctpwm_mode_e'(ctrl1_r[B_MODE +: 2]);
  assign ofn     = ctpwm_ofn_e'(ctrl1_r[B_OFN +: 2]);
  assign oc      = ctrl1_r[B_OC];
  assign pol     = ctrl1_r[B_POL];
  assign dpx     = ctrl1_r[B_DPX];
  assign ccl     = ctrl1_r[B_CCL];
  assign is_pwm  = (mode == CTPWM_PWM);
  assign is_cmo  = (mode == CTPWM_CMP_A) || (mode == CTPWM_CMP_B);
  assign restart = on_r && !on_prev_r;

  ctpwm_count #(
    .CNT_W (CNT_W),
    .P_W   (P_W)
  ) u_count (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .run      (on_r),
    .restart  (restart),
    .mode     (mode),
    .ccl      (ccl),
    .dpx      (dpx),
    .cmpa     (cmpa_r),
    .cmpp     (cmpp_r),
    .count    (count),
    .hit_a    (hit_a),
    .hit_p    (hit_p),
    .wave_act (wave_act)
  );

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic       req;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic       wr_ctrl1;
  logic       wr_ctrl0;
  logic       wr_alo;
  logic       wr_ahi;
  logic       wr_p;
  logic       wr_stat;

  assign req   = wb_cyc && wb_stb;
  // commit on the edge where the master sees ack
  assign wr_en = req && wb_we && ack_r && wb_sel[0];
  assign wbyte = wb_dat_w[7:0];
  assign wr_ctrl1 = wr_en && (wb_adr == OFS_CTRL1);
  assign wr_ctrl0 = wr_en && (wb_adr == OFS_CTRL0);
  assign wr_alo   = wr_en && (wb_adr == OFS_CMPA_LO);
  assign wr_ahi   = wr_en && (wb_adr == OFS_CMPA_HI);
  assign wr_p     = wr_en && (wb_adr == OFS_CMPP);
  assign wr_stat  = wr_en && (wb_adr == OFS_STAT);

  // unmapped words read as zero and still answer
  assign rd_byte =
      (wb_adr == OFS_CTRL1)   ? ctrl1_r
    : (wb_adr == OFS_CTRL0)   ? (8'(on_r) << B_ON)
    : (wb_adr == OFS_CNT_LO)  ? count[7:0]
    : (wb_adr == OFS_CNT_HI)  ? 8'(count[CNT_W-1:8])
    : (wb_adr == OFS_CMPA_LO) ? cmpa_r[7:0]
    : (wb_adr == OFS_CMPA_HI) ? 8'(cmpa_r[CNT_W-1:8])
    : (wb_adr == OFS_CMPP)    ? 8'(cmpp_r)
    : (wb_adr == OFS_STAT)    ? ((8'(fa_r) << B_FA) | (8'(fp_r) << B_FP))
    : 8'h00;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req && !ack_r;
      rdat_r <= (req && !ack_r) ? {24'h00_0000, rd_byte} : rdat_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_r   <= CTRL1_RST;
      on_r      <= ON_RST;
      on_prev_r <= ON_RST;
      cmpa_r    <= {CMPA_RST[CNT_W-9:0], CMPA_RST};
      cmpp_r    <= CMPP_RST[P_W-1:0];
    end else begin
      ctrl1_r   <= wr_ctrl1 ? wbyte : ctrl1_r;
      on_r      <= wr_ctrl0 ? wbyte[B_ON] : on_r;
      on_prev_r <= on_r;
      cmpa_r[7:0]       <= wr_alo ? wbyte : cmpa_r[7:0];
      cmpa_r[CNT_W-1:8] <= wr_ahi ? wbyte[CNT_W-9:0] : cmpa_r[CNT_W-1:8];
      cmpp_r    <= wr_p ? wbyte[P_W-1:0] : cmpp_r;
    end
  end

  // ****************************************************************
  // match flags: a new match beats a same-cycle clear
  // ****************************************************************
  logic fa_nxt;
  logic fp_nxt;

  assign fa_nxt = hit_a || (fa_r && !(wr_stat && wbyte[B_FA]));
  assign fp_nxt = hit_p || (fp_r && !(wr_stat && wbyte[B_FP]));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fa_r <= 1'b0;
      fp_r <= 1'b0;
    end else begin
      fa_r <= fa_nxt;
      fp_r <= fp_nxt;
    end
  end

  // ****************************************************************
  // pin logic
  // ****************************************************************
  logic cmo_nxt;
  logic pwm_lvl;
  logic pin_nxt;

  // function code sets low, high or toggle on an a match only
  assign cmo_nxt =
      restart                       ? oc
    : !(hit_a && is_cmo)            ? cmo_st_r
    : (ofn == CTPWM_FORCE_ON)       ? 1'b0
    : (ofn == CTPWM_WAVE)           ? 1'b1
    : (ofn == CTPWM_UNDEF)          ? !cmo_st_r
    : cmo_st_r;

  // undefined code parks at inactive; counter runs regardless of the code
  assign pwm_lvl =
      (ofn == CTPWM_WAVE)     ? (wave_act ? oc : !oc)
    : (ofn == CTPWM_FORCE_ON) ? oc
    : !oc;

  assign pin_nxt = is_pwm ? (pwm_lvl ^ pol)
                 : is_cmo ? (cmo_st_r ^ pol)
                 : 1'b0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmo_st_r <= 1'b0;
      pin_r    <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      cmo_st_r <= cmo_nxt;
      pin_r    <= pin_nxt;
      oe_r     <= (mode != CTPWM_TC);
    end
  end

  assign wb_ack       = ack_r;
  assign wb_dat_r     = rdat_r;
  assign pin_out      = pin_r;
  assign pin_oe       = oe_r;
  assign match_a_flag = fa_r;
  assign match_p_flag = fp_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_clear_cmo_a: assert property (
    (!is_pwm && ccl && hit_a && !restart) |=> (count == '0))
    else $error("compare a match did not clear counter");

  cmo_pin_hold_a: assert property (
    (is_cmo && !hit_a && !restart) |=> $stable(cmo_st_r))
    else $error("pin state moved without a match");

  restart_level_a: assert property (
    restart |=> (cmo_st_r == $past(oc)))
    else $error("pin not back at initial level");

  no_p_flag_a: assert property (
    (!is_pwm && ccl && !fp_r) |=> !fp_r)
    else $error("p flag set while clear select high");

  tc_release_a: assert property (
    (mode == CTPWM_TC) [*2] |-> !pin_oe)
    else $error("pin driven in timer/counter mode");

  pwm_a_clear_a: assert property (
    (is_pwm && dpx && hit_a && !restart) |=> (count == '0))
    else $error("pwm period not cleared by compare a");

  flag_set_a: assert property (
    (hit_a && hit_p) |=> (match_a_flag && match_p_flag))
    else $error("match flag lost");

  full_duty_a: assert property (
    (is_pwm && ofn == CTPWM_WAVE && wave_act) |=> (pin_out == $past(oc ^ pol)))
    else $error("active window not on pin");

  forced_run_a: assert property (
    (is_pwm && ofn == CTPWM_FORCE_OFF && on_r && !restart && !hit_p && !hit_a)
      |=> (count == $past(count) + 1'b1))
    else $error("counter stopped while pin forced");

  p_code_a: assert property (
    (on_r && !restart && is_pwm && cmpp_r == 1 && count == 127) |-> hit_p)
    else $error("p code one missed at count 127");

  off_hold_a: assert property (
    !on_r |=> $stable(count))
    else $error("counter moved while timer off");

  tc_pin_low_a: assert property (
    (mode == CTPWM_TC) |=> !pin_out)
    else $error("pin level driven in timer/counter mode");

  forced_on_a: assert property (
    (is_pwm && ofn == CTPWM_FORCE_ON) |=> (pin_out == $past(oc ^ pol)))
    else $error("forced active level not on pin");

  cover_pwm_wrap: cover property (is_pwm && hit_p ##1 count == '0);
  cover_toggle: cover property (is_cmo && ofn == CTPWM_UNDEF && hit_a ##1 $changed(cmo_st_r));
  cover_set_vs_clr: cover property (hit_a && wr_stat && wbyte[B_FA]);
  cover_tc_flag: cover property (mode == CTPWM_TC && hit_a);

endmodule : ctpwm_top

// ==== ctpwm_pkg.sv ====
// Purpose: shared constants and types of the compact compare/pwm timer
// Assumes: one 125 MHz clock (8 ns), counter advances once per clock
// Notes:   byte-wide registers sit in the low lane of 32-bit wishbone words
package ctpwm_pkg;

  // ****************************************************************
  // counter geometry
  // ****************************************************************
  localparam int CNT_W = 10;
  localparam int P_W   = 3;

  // ****************************************************************
  // modes and output functions
  // ****************************************************************
  typedef enum logic [1:0] {
    CTPWM_CMP_A,
    CTPWM_CMP_B,
    CTPWM_PWM,
    CTPWM_TC
  } ctpwm_mode_e;

  typedef enum logic [1:0] {
    CTPWM_FORCE_OFF,
    CTPWM_FORCE_ON,
    CTPWM_WAVE,
    CTPWM_UNDEF
  } ctpwm_ofn_e;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL1   = 8'h00;
  localparam logic [7:0] OFS_CTRL0   = 8'h04;
  localparam logic [7:0] OFS_CNT_LO  = 8'h08;
  localparam logic [7:0] OFS_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_CMPP    = 8'h18;
  localparam logic [7:0] OFS_STAT    = 8'h1c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int B_MODE = 6;
  localparam int B_OFN  = 4;
  localparam int B_OC   = 3;
  localparam int B_POL  = 2;
  localparam int B_DPX  = 1;
  localparam int B_CCL  = 0;
  localparam int B_ON   = 3;
  localparam int B_FA   = 0;
  localparam int B_FP   = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic       ON_RST    = 1'b0;
  localparam logic [7:0] CMPA_RST  = 8'h00;
  localparam logic [7:0] CMPP_RST  = 8'h00;

endpackage : ctpwm_pkg

// ==== ctpwm_count.sv ====
// Purpose: up-counter, comparators a and p, pwm active window
// Assumes: cmpp is compared with the top P_W counter bits
// Notes:   matches look at count+1 so a clear lands exactly on the period
module ctpwm_count #(
  parameter int CNT_W = ctpwm_pkg::CNT_W,
  parameter int P_W   = ctpwm_pkg::P_W
) (
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               run,
  input  wire logic               restart,
  input  wire ctpwm_pkg::ctpwm_mode_e mode,
  input  wire logic               ccl,
  input  wire logic               dpx,
  input  wire logic [CNT_W-1:0]   cmpa,
  input  wire logic [P_W-1:0]     cmpp,
  output logic      [CNT_W-1:0]   count,
  output logic                    hit_a,
  output logic                    hit_p,
  output logic                    wave_act
);
  import ctpwm_pkg::*;

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (P_W < 1 || CNT_W <= P_W + 1) begin : g_bad
    $error("ctpwm_count: CNT_W must exceed P_W + 1");
  end

  // ****************************************************************
  // compare and clear
  // ****************************************************************
  function automatic logic [CNT_W:0] p_len(input logic [P_W-1:0] c);
    logic [CNT_W:0] v;
    v = '0;
    if (c == '0) begin
      v[CNT_W] = 1'b1;
    end else begin
      v[CNT_W-1 -: P_W] = c;
    end
    return v;
  endfunction : p_len

  logic [CNT_W-1:0] cnt_inc;
  logic             a_eq;
  logic             p_eq;
  logic             is_pwm;
  logic             clr;
  logic [CNT_W:0]   period_v;
  logic [CNT_W:0]   duty_v;
  logic [CNT_W:0]   a_len;
  logic [CNT_W-1:0] count_nxt;

  assign cnt_inc = count + 1'b1;
  assign a_eq    = (cnt_inc == cmpa);
  // code zero lands on cnt_inc == 0, i.e. overflow
  assign p_eq    = (cnt_inc[CNT_W-1 -: P_W] == cmpp)
                && (cnt_inc[CNT_W-P_W-1:0] == '0);
  assign is_pwm  = (mode == CTPWM_PWM);
  // a zero compare a raises no flag outside pwm
  // a restart drops the stale count, so it raises no match
  assign hit_a   = run && !restart && a_eq && (is_pwm || cmpa != '0);
  assign hit_p   = run && !restart && p_eq && (is_pwm || !ccl);
  assign clr     = is_pwm ? (dpx ? a_eq : p_eq)
                          : (ccl ? a_eq : p_eq);

  // ****************************************************************
  // pwm window
  // ****************************************************************
  assign a_len    = (cmpa == '0) ? p_len('0) : {1'b0, cmpa};
  assign period_v = dpx ? a_len : p_len(cmpp);
  assign duty_v   = dpx ? p_len(cmpp) : {1'b0, cmpa};
  assign wave_act = (duty_v >= period_v) || ({1'b0, count} < duty_v);

  assign count_nxt = restart ? '0
                   : !run    ? count
                   : clr     ? '0
                   : cnt_inc;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= count_nxt;
    end
  end

endmodule : ctpwm_count

// ==== ctpwm_load.sv ====
// Purpose: external load on the timer output pin, with a pull-up and a level meter
// Assumes: pin sampled once per sys_clk rising edge
// Notes:   counters cleared while meas_en is low
module ctpwm_load (
  input  wire logic        sys_clk,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  input  wire logic        meas_en,
  output logic             pad,
  output logic [15:0]      high_cnt,
  output logic [15:0]      rise_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // pad level and meter
  // ****************************************************************
  logic pad_q_r;

  // released pin goes to the pull-up, never keeps the last driven value
  assign pad = pin_oe ? pin_out : 1'b1;

  always_ff @(posedge sys_clk) begin
    pad_q_r <= pad;
    if (!meas_en) begin
      high_cnt <= 16'h0;
      rise_cnt <= 16'h0;
    end else begin
      if (pad) high_cnt <= high_cnt + 16'h1;
      if (pad && !pad_q_r) rise_cnt <= rise_cnt + 16'h1;
    end
  end
endmodule : ctpwm_load

// ==== ctpwm_top_tb_top.sv ====
// Purpose: self-checking bench of the compact compare/pwm timer
// Assumes: 125 MHz sys_clk, classic wishbone single cycles
// Notes:   pin waveforms judged by high-time and edge counts over whole periods
module ctpwm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ctpwm_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk;
  logic        arst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        pin_out;
  logic        pin_oe;
  logic        match_a_flag;
  logic        match_p_flag;
  logic        meas_en;
  logic        pad;
  logic [15:0] high_cnt;
  logic [15:0] rise_cnt;
  int          n_fail;
  int          tests_run;

  ctpwm_top ctpwm_top_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pin_out(pin_out), .pin_oe(pin_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

  ctpwm_load ctpwm_load_i (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .meas_en(meas_en),
    .pad(pad), .high_cnt(high_cnt), .rise_cnt(rise_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task test_done;
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // master holds the request until ack is sampled, then idles one cycle
  task wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
          output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= {24'h0, d};
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (wb_ack === 1'b1) break;
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i == 16) begin
      n_fail++;
      test_done();
    end
    @(posedge sys_clk);
  endtask : wb

  task wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask : wr

  task rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 8'h0, q);
    chk(q, exp);
  endtask : rdchk

  // stop, program, clear flags, restart; config only changes while off
  task cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, c1);
    wr(OFS_CMPA_LO, a[7:0]);
    wr(OFS_CMPA_HI, {6'h0, a[9:8]});
    wr(OFS_CMPP, {5'h0, p});
    wr(OFS_STAT, 8'h03);
    wr(OFS_CTRL0, 8'h08);
    repeat (4) @(posedge sys_clk);
  endtask : cfg

  task measure(input int n, output logic [15:0] hi, output logic [15:0] rs);
    @(posedge sys_clk);
    meas_en <= 1'b1;
    repeat (n) @(posedge sys_clk);
    meas_en <= 1'b0;
    @(negedge sys_clk);
    hi = high_cnt;
    rs = rise_cnt;
  endtask : measure

  task pwm_case(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p,
                input int n, input logic [31:0] eh, input logic [31:0] er,
                input logic [31:0] ef);
    logic [15:0] hi;
    logic [15:0] rs;
    cfg(c1, a, p);
    measure(n, hi, rs);
    chk({16'h0, hi}, eh);
    chk({16'h0, rs}, er);
    chk({30'h0, match_p_flag, match_a_flag}, ef);
    rdchk(OFS_STAT, ef);
  endtask : pwm_case

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    int i;
    for (i = 0; i < 9; i++) rdchk(8'(i * 4), 32'h0);
    chk({31'h0, pin_oe}, 32'h1);
    wr(OFS_CMPA_HI, 8'hff);
    rdchk(OFS_CMPA_HI, 32'h3);
    wr(OFS_CMPA_LO, 8'h5a);
    rdchk(OFS_CMPA_LO, 32'h5a);
    wr(OFS_CMPP, 8'hff);
    rdchk(OFS_CMPP, 32'h7);
    wr(OFS_CNT_LO, 8'hff);
    rdchk(OFS_CNT_LO, 32'h0);
    wb_sel <= 4'h0;
    wr(OFS_CTRL1, 8'hff);
    wb_sel <= 4'h1;
    rdchk(OFS_CTRL1, 32'h0);
    wr(8'h20, 8'hff);
    rdchk(8'h20, 32'h0);
  endtask : t_regs

  task t_pwm;
    pwm_case(8'ha8, 10'h020, 3'h1, 256, 32'h40, 32'h2, 32'h3);
    pwm_case(8'ha9, 10'h020, 3'h1, 256, 32'h40, 32'h2, 32'h3);
    pwm_case(8'hac, 10'h020, 3'h1, 256, 32'hc0, 32'h2, 32'h3);
    pwm_case(8'ha0, 10'h020, 3'h1, 256, 32'hc0, 32'h2, 32'h3);
    pwm_case(8'h88, 10'h020, 3'h1, 256, 32'h0, 32'h0, 32'h3);
    pwm_case(8'h98, 10'h020, 3'h1, 256, 32'h100, 32'h0, 32'h3);
    pwm_case(8'hb8, 10'h020, 3'h1, 256, 32'h0, 32'h0, 32'h3);
    pwm_case(8'ha8, 10'h0c8, 3'h1, 256, 32'h100, 32'h0, 32'h2);
    // duty equal to period: both matches land in one cycle
    pwm_case(8'ha8, 10'h080, 3'h1, 256, 32'h100, 32'h0, 32'h3);
    pwm_case(8'haa, 10'h12c, 3'h1, 600, 32'h100, 32'h2, 32'h3);
    pwm_case(8'ha8, 10'h100, 3'h0, 1024, 32'h100, 32'h1, 32'h3);
  endtask : t_pwm

  task t_compare;
    logic [15:0] hi;
    logic [15:0] rs;
    logic [31:0] q;
    logic [31:0] q2;
    int          i;
    // toggle on a match, a clears at 200, p value 127 reached but inert
    cfg(8'h31, 10'h0c8, 3'h1);
    measure(400, hi, rs);
    chk({16'h0, hi}, 32'hc8);
    chk({16'h0, rs}, 32'h1);
    rdchk(OFS_STAT, 32'h1);
    chk({31'h0, pin_oe}, 32'h1);
    for (i = 0; i < 400 && pin_out !== 1'b1; i++) @(posedge sys_clk);
    chk({31'h0, pin_out}, 32'h1);
    wr(OFS_CTRL0, 8'h00);
    wb(1'b0, OFS_CNT_LO, 8'h0, q);
    repeat (10) @(posedge sys_clk);
    wb(1'b0, OFS_CNT_LO, 8'h0, q2);
    chk(q2, q);
    rdchk(OFS_CNT_HI, 32'h0);
    wr(OFS_CTRL0, 8'h08);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pin_out}, 32'h0);
    wb(1'b0, OFS_CNT_LO, 8'h0, q);
    chk({31'h0, q < 32'h8}, 32'h1);
  endtask : t_compare

  task t_timer;
    logic [15:0] hi;
    logic [15:0] rs;
    cfg(8'hc0, 10'h028, 3'h1);
    measure(256, hi, rs);
    chk({31'h0, pin_oe}, 32'h0);
    chk({16'h0, hi}, 32'h100);
    rdchk(OFS_STAT, 32'h3);
  endtask : t_timer

  // compare codes low, high and none; mode 01 must act as compare mode
  task t_codes;
    pwm_case(8'h58, 10'h040, 3'h1, 256, 32'h3c, 32'h0, 32'h3);
    pwm_case(8'h60, 10'h040, 3'h1, 256, 32'hc4, 32'h1, 32'h3);
    pwm_case(8'h08, 10'h040, 3'h1, 256, 32'h100, 32'h0, 32'h3);
  endtask : t_codes

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    n_fail    = 0;
    tests_run = 0;
    arst_n    = 1'b0;
    wb_cyc    = 1'b0;
    wb_stb    = 1'b0;
    wb_we     = 1'b0;
    wb_adr    = 8'h0;
    wb_sel    = 4'h1;
    wb_dat_w  = 32'h0;
    meas_en   = 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_pwm();
    t_compare();
    t_timer();
    t_codes();
    test_done();
  end
endmodule : ctpwm_top_tb_top
